// File: core_flags_alu_stack_unit.sv
/*
 * Core context unit: per-level flag sets with automatic save and restore,
 * 8-bit ALU with multiply, divide and offset arithmetic, 256-byte register
 * file, flag status, and system and user stack pointers.
 * Assumes a control unit issues one ALU or stack request per cycle and a
 * RAM bank answers a read while its registered address stands.
 */
// How it works
// - Each interrupt level owns flags, restored on interrupt return.
// - Call and subroutine return leave normal flags alone.
// - Flags never cleared on context switch; each set keeps last value.
// - Add, sub and offset ops: carry marks overflow, sign marks underflow, otherwise cleared.
// - Flag status at 026h: zero bit2, sign bit1, carry bit0, reset 00h.
// - ALU: add, sub, and, or, xor, bit set/reset/test, shift, rotate.
// - Multiply two bytes, sixteen-bit product into two registers.
// - Divide reads high byte then next; quotient, remainder written back.
// - Offset add subtracts 128, offset subtract adds 128.
// - 256 byte registers usable as operands; register move copies.
// - Addresses 0..2 reset jump, 3..32 three-byte interrupt vectors.
// - Membership data follows vectors, ends by 1023; rest is program.
// - 3000h..307Fh reserved option bytes, 3000h..3007h used.
// - Nonvolatile memory starts at zero, RAM banks lie after it.
// - Call or interrupt stores counter at pointer, pointer drops two.
// - Returns raise pointer by two, reload counter from those bytes.
// - System pointer at config 02Ch (page fixed 020h) and 02Dh.
// - System stack from 20FFh; system low 255, user low 0 at reset.
// - User top page 005h, location 006h; pages above 32 map to 32.
// - Writing user stack top also loads the user stack pointer.
// - Push stores then increments; pop decrements then copies byte.
// - User pointer readable at input registers 0Bh (page 020h), 0Ch.
// - Program counter is sixteen bits, so stack entries are two bytes.
// - Every flag set has carry, zero and sign, stacked automatically.
`timescale 1ns/10ps
`default_nettype none
`include "core_ctx_regs.svh"

module core_flags_alu_stack_unit #(
	parameter int IRQ_LEVELS = 8
) (
	// Clock and reset.
	input  wire logic                    clk_sys_in,
	input  wire logic                    reset_n_in,
	// ALU requests from the control unit.
	input  wire core_ctx_pkg::alu_req_s  alu_req_in,
	// Stack requests from the control unit.
	input  wire core_ctx_pkg::stack_req_s stack_req_in,
	input  wire logic [7:0]              ram_rdata_in,
	// Configuration and input register access.
	input  wire core_ctx_pkg::cfg_req_s  cfg_req_in,
	input  wire logic [7:0]              reg_rd_addr_in,
	// Answers.
	output logic [7:0]                   cfg_rdata_out,
	output logic [7:0]                   reg_rdata_out,
	output logic                         branch_taken_out,
	output logic [15:0]                  pc_restore_out,
	output logic                         pc_restore_valid_out,
	output logic                         busy_out,
	output core_ctx_pkg::flags_s         flags_out,
	output core_ctx_pkg::mem_req_s       mem_req_out
);
	import core_ctx_pkg::*;

	// -----------------------------------------------------------------
	// Parameter check
	// -----------------------------------------------------------------
	// Level 0 is normal mode; at least one interrupt level must exist.
	localparam int LW = $clog2(IRQ_LEVELS + 1);
	if (IRQ_LEVELS < 1 || IRQ_LEVELS > 15) begin : g_bad_levels
		$error("IRQ_LEVELS must lie between 1 and 15.");
	end
	// Vectors follow the reset jump, data ends below RAM, options fit.
	if (`IRQ_VEC_FIRST != `RESET_VEC_LAST + 16'h0001 ||
			`MBF_LAST >= `RAM_BASE ||
			`OPTION_USED_LAST > `OPTION_LAST) begin : g_bad_map
		$error("Memory layout constants are inconsistent.");
	end

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef enum logic [4:0] {
		st_idle  = 5'b00001,
		st_push2 = 5'b00010,
		st_pop1  = 5'b00100,
		st_pop2  = 5'b01000,
		st_upop  = 5'b10000
	} seq_e;

	typedef struct packed {
		seq_e                          seq;
		logic [IRQ_LEVELS:0][2:0]      fset;
		logic [LW-1:0]                 level;
		logic [7:0]                    system_stack_pointer_page;
		logic [7:0]                    user_stack_pointer_page;
		logic [7:0]                    ust_page;
		logic [7:0]                    ust_loc;
		logic [255:0][7:0]             rf;
		logic [15:0]                   pc_hold;
		logic [7:0]                    pop_dst;
		logic                          pop_irq;
		logic [7:0]                    cfg_rdata;
		logic [7:0]                    reg_rdata;
		logic                          branch;
		logic [15:0]                   pc_out;
		logic                          pc_valid;
		mem_req_s                      mem;
	} state_s;

	state_s state;
	state_s next_state;
	logic   rst_meta;
	logic   rst_sync_n;

	// -----------------------------------------------------------------
	// Functions
	// -----------------------------------------------------------------
	// Stack addresses always sit in the fixed RAM page.
	function automatic logic [15:0] page_addr(input logic [7:0] loc);
		page_addr = {`STACK_PAGE, loc};
	endfunction : page_addr

	// Zero, sign and carry packed in flag-register order.
	function automatic logic [2:0] mk_flags(input logic [7:0] r,
			input logic s, input logic c);
		mk_flags = {(r == 8'h00), s, c};
	endfunction : mk_flags

	// -----------------------------------------------------------------
	// Reset release
	// -----------------------------------------------------------------
	// Two stages so reset deasserts cleanly on the clock.
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		logic [7:0]  a;
		logic [7:0]  b;
		logic [8:0]  wide;
		logic [9:0]  off;
		logic [15:0] prod;
		logic [15:0] dvd;
		logic [2:0]  f;
		logic        upd;
		a    = 8'h00;
		b    = 8'h00;
		wide = 9'h000;
		off  = 10'h000;
		prod = 16'h0000;
		dvd  = 16'h0000;
		upd  = 1'b0;
		next_state = state;
		f = state.fset[state.level];
		next_state.branch   = 1'b0;
		next_state.pc_valid = 1'b0;
		next_state.mem.mem_we = 1'b0;

		// ALU operations read any register file location.
		a = state.rf[alu_req_in.src_a];
		b = state.rf[alu_req_in.src_b];
		if (alu_req_in.valid) begin
			unique case (alu_req_in.op)
				alu_add: begin
					wide = {1'b0, a} + {1'b0, b};
					next_state.rf[alu_req_in.dst] = wide[7:0];
					f = mk_flags(wide[7:0], 1'b0, wide[8]);
					upd = 1'b1;
				end
				alu_sub: begin
					wide = {1'b0, a} - {1'b0, b};
					next_state.rf[alu_req_in.dst] = wide[7:0];
					f = mk_flags(wide[7:0], wide[8], 1'b0);
					upd = 1'b1;
				end
				offset_add_op: begin
					off = {2'b00, a} + {2'b00, b} - {2'b00, `OFFSET_BIAS};
					next_state.rf[alu_req_in.dst] = off[7:0];
					f = mk_flags(off[7:0], off[9], ~off[9] & off[8]);
					upd = 1'b1;
				end
				offset_subtract_op: begin
					off = {2'b00, a} - {2'b00, b} + {2'b00, `OFFSET_BIAS};
					next_state.rf[alu_req_in.dst] = off[7:0];
					f = mk_flags(off[7:0], off[9], ~off[9] & off[8]);
					upd = 1'b1;
				end
				alu_and, alu_or, alu_xor: begin
					unique case (alu_req_in.op)
						alu_and: wide[7:0] = a & b;
						alu_or:  wide[7:0] = a | b;
						default: wide[7:0] = a ^ b;
					endcase
					next_state.rf[alu_req_in.dst] = wide[7:0];
					f = mk_flags(wide[7:0], 1'b0, 1'b0);
					upd = 1'b1;
				end
				alu_bset: begin
					next_state.rf[alu_req_in.dst][alu_req_in.bit_sel] = 1'b1;
				end
				alu_bres: begin
					next_state.rf[alu_req_in.dst][alu_req_in.bit_sel] = 1'b0;
				end
				alu_btest: begin
					next_state.branch = a[alu_req_in.bit_sel];
				end
				alu_shl, alu_shr, alu_rol, alu_ror: begin
					unique case (alu_req_in.op)
						alu_shl: wide = {a, 1'b0};
						alu_shr: wide = {a[0], 1'b0, a[7:1]};
						alu_rol: wide = {a, a[7]};
						default: wide = {a[0], a[0], a[7:1]};
					endcase
					next_state.rf[alu_req_in.dst] = wide[7:0];
					f = mk_flags(wide[7:0], 1'b0, wide[8]);
					upd = 1'b1;
				end
				multiply_op: begin
					prod = a * b;
					next_state.rf[alu_req_in.dst] = prod[15:8];
					next_state.rf[8'(alu_req_in.dst + 8'h01)] = prod[7:0];
					f = mk_flags(8'(prod[15:8] | prod[7:0]), 1'b0, 1'b0);
					upd = 1'b1;
				end
				divide_op: begin
					// Divide by zero leaves the dividend and sets carry.
					dvd = {a, state.rf[8'(alu_req_in.src_a + 8'h01)]};
					if (b != 8'h00) begin
						next_state.rf[alu_req_in.src_a] = 8'(dvd / {8'h00, b});
						next_state.rf[8'(alu_req_in.src_a + 8'h01)] =
							8'(dvd % {8'h00, b});
						f = mk_flags(8'(dvd / {8'h00, b}), 1'b0, 1'b0);
					end else begin
						f = mk_flags(a, 1'b0, 1'b1);
					end
					upd = 1'b1;
				end
				register_move_op: begin
					next_state.rf[alu_req_in.dst] = a;
				end
				default: begin
				end
			endcase
		end
		// Only the current level's set changes.
		if (upd) begin
			next_state.fset[state.level] = f;
		end

		// Stack sequencer.
		unique case (state.seq)
			st_idle: begin
				if (stack_req_in.valid) begin
					unique case (stack_req_in.cmd)
						cmd_call, cmd_irq: begin
							// Low byte at the pointer, high byte below it.
							next_state.mem.mem_we    = 1'b1;
							next_state.mem.mem_addr  = page_addr(state.system_stack_pointer_page);
							next_state.mem.mem_wdata = stack_req_in.pc[7:0];
							next_state.pc_hold = stack_req_in.pc;
							next_state.seq = st_push2;
							// Interrupt entry switches to the next level's set, up to level IRQ_LEVELS.
							if (stack_req_in.cmd == cmd_irq &&
									state.level < LW'(IRQ_LEVELS)) begin
								next_state.level = LW'(state.level + 1'b1);
							end
						end
						subroutine_return, interrupt_return: begin
							next_state.system_stack_pointer_page = 8'(state.system_stack_pointer_page + `STACK_STEP);
							next_state.mem.mem_addr =
								page_addr(8'(state.system_stack_pointer_page + 8'h01));
							next_state.pop_irq = stack_req_in.cmd == interrupt_return;
							next_state.seq = st_pop1;
						end
						cmd_push: begin
							next_state.mem.mem_we    = 1'b1;
							next_state.mem.mem_addr  = page_addr(state.user_stack_pointer_page);
							next_state.mem.mem_wdata = state.rf[stack_req_in.reg_addr];
							next_state.user_stack_pointer_page = 8'(state.user_stack_pointer_page + 8'h01);
						end
						cmd_pop: begin
							next_state.user_stack_pointer_page = 8'(state.user_stack_pointer_page - 8'h01);
							next_state.mem.mem_addr =
								page_addr(8'(state.user_stack_pointer_page - 8'h01));
							next_state.pop_dst = stack_req_in.reg_addr;
							next_state.seq = st_upop;
						end
						default: begin
						end
					endcase
				end
			end
			st_push2: begin
				next_state.mem.mem_we    = 1'b1;
				next_state.mem.mem_addr  = page_addr(8'(state.system_stack_pointer_page - 8'h01));
				next_state.mem.mem_wdata = state.pc_hold[15:8];
				next_state.system_stack_pointer_page = 8'(state.system_stack_pointer_page - `STACK_STEP);
				next_state.seq = st_idle;
			end
			st_pop1: begin
				next_state.pc_hold[15:8] = ram_rdata_in;
				next_state.mem.mem_addr = page_addr(state.system_stack_pointer_page);
				next_state.seq = st_pop2;
			end
			st_pop2: begin
				next_state.pc_out   = {state.pc_hold[15:8], ram_rdata_in};
				next_state.pc_valid = 1'b1;
				// Leaving a level restores the set below; subroutine return
				// leaves the flag sets alone.
				if (state.pop_irq && state.level != '0) begin
					next_state.level = LW'(state.level - 1'b1);
				end
				next_state.seq = st_idle;
			end
			st_upop: begin
				next_state.rf[state.pop_dst] = ram_rdata_in;
				next_state.seq = st_idle;
			end
			default: begin
				next_state.seq = st_idle;
			end
		endcase

		// Configuration writes; the user top page byte is kept as written, stacks stay in page 32.
		if (cfg_req_in.wr) begin
			unique case (cfg_req_in.addr)
				`SSP_LOC_ADDR: next_state.system_stack_pointer_page = cfg_req_in.wdata;
				`UST_PAGE_ADDR: begin
					next_state.ust_page = cfg_req_in.wdata;
					next_state.user_stack_pointer_page = state.ust_loc;
				end
				`UST_LOC_ADDR: begin
					next_state.ust_loc = cfg_req_in.wdata;
					next_state.user_stack_pointer_page = cfg_req_in.wdata;
				end
				default: begin
				end
			endcase
		end

		// Configuration reads.
		unique case (cfg_req_in.addr)
			`SSP_PAGE_ADDR: next_state.cfg_rdata = `STACK_PAGE;
			`SSP_LOC_ADDR:  next_state.cfg_rdata = state.system_stack_pointer_page;
			`UST_PAGE_ADDR: next_state.cfg_rdata = state.ust_page;
			`UST_LOC_ADDR:  next_state.cfg_rdata = state.ust_loc;
			default:        next_state.cfg_rdata = 8'h00;
		endcase

		// Input register reads.
		unique case (reg_rd_addr_in)
			`USP_PAGE_ADDR:    next_state.reg_rdata = `STACK_PAGE;
			`USP_LOC_ADDR:     next_state.reg_rdata = state.user_stack_pointer_page;
			`FLAG_STATUS_ADDR: next_state.reg_rdata =
				{5'h00, state.fset[state.level]};
			default:           next_state.reg_rdata = 8'h00;
		endcase
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	// The register file also resets, which costs area but keeps X out.
	always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state          <= '0;
			state.seq      <= st_idle;
			state.system_stack_pointer_page      <= `SSP_LOC_RESET;
			state.user_stack_pointer_page      <= `USP_LOC_RESET;
			state.ust_page <= `STACK_PAGE;
			state.ust_loc  <= `USP_LOC_RESET;
		end else begin
			state <= next_state;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// Memory map (reset, vectors, data, options, RAM) is the control
	// unit's concern; only the RAM page is used here.
	assign cfg_rdata_out        = state.cfg_rdata;
	assign reg_rdata_out        = state.reg_rdata;
	assign branch_taken_out     = state.branch;
	assign pc_restore_out       = state.pc_out;
	assign pc_restore_valid_out = state.pc_valid;
	assign busy_out             = state.seq != st_idle;
	assign flags_out            = flags_s'(state.fset[state.level]);
	assign mem_req_out          = state.mem;

endmodule : core_flags_alu_stack_unit

`default_nettype wire

// File: core_ctx_regs.svh
/*
 * Constants of the core context unit: register offsets, reset values,
 * memory layout addresses and field positions.
 * Assumes it is included by its bare name from the design; the package does not include it.
 */
`ifndef CORE_CTX_REGS_SVH
`define CORE_CTX_REGS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define UST_PAGE_ADDR       8'h05
`define UST_LOC_ADDR        8'h06
`define USP_PAGE_ADDR       8'h0B
`define USP_LOC_ADDR        8'h0C
`define FLAG_STATUS_ADDR    8'h26
`define SSP_PAGE_ADDR       8'h2C
`define SSP_LOC_ADDR        8'h2D

// ---------------------------------------------------------------------
// Reset values and fixed fields
// ---------------------------------------------------------------------
`define STACK_PAGE          8'h20
`define SSP_LOC_RESET       8'hFF
`define USP_LOC_RESET       8'h00
`define FLAG_RESET          3'h0
`define FLAG_BIT_C          0
`define FLAG_BIT_S          1
`define FLAG_BIT_Z          2
`define OFFSET_BIAS         8'h80
`define STACK_STEP          8'h02

// ---------------------------------------------------------------------
// Program memory layout
// ---------------------------------------------------------------------
`define RESET_VEC_LAST      16'h0002
`define IRQ_VEC_FIRST       16'h0003
`define IRQ_VEC_LAST        16'h0020
`define MBF_LAST            16'h03FF
`define OPTION_FIRST        16'h3000
`define OPTION_USED_LAST    16'h3007
`define OPTION_LAST         16'h307F
`define RAM_BASE            16'h2000

`endif

// File: core_ctx_pkg.sv
/*
 * Types of the core context unit: ALU operation codes, control commands,
 * the flag set and the bundles of requests and answers.
 * Assumes core_ctx_regs.svh is visible by bare name.
 */
`default_nettype none

package core_ctx_pkg;

	// -----------------------------------------------------------------
	// Operation codes
	// -----------------------------------------------------------------
	typedef enum logic [4:0] {
		alu_add, alu_sub, alu_and, alu_or, alu_xor, alu_bset, alu_bres,
		alu_btest, alu_shl, alu_shr, alu_rol, alu_ror, multiply_op,
		divide_op, offset_add_op, offset_subtract_op, register_move_op,
		alu_none
	} alu_op_e;

	typedef enum logic [2:0] {
		cmd_none, cmd_call, cmd_irq, subroutine_return, interrupt_return,
		cmd_push, cmd_pop
	} stack_cmd_e;

	// -----------------------------------------------------------------
	// Flag set and buses
	// -----------------------------------------------------------------
	typedef struct packed {
		logic z;
		logic s;
		logic c;
	} flags_s;

	typedef struct packed {
		logic        valid;
		alu_op_e     op;
		logic [7:0]  src_a;
		logic [7:0]  src_b;
		logic [7:0]  dst;
		logic [2:0]  bit_sel;
	} alu_req_s;

	typedef struct packed {
		logic        valid;
		stack_cmd_e  cmd;
		logic [15:0] pc;
		logic [7:0]  reg_addr;
	} stack_req_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} cfg_req_s;

	typedef struct packed {
		logic        mem_we;
		logic [15:0] mem_addr;
		logic [7:0]  mem_wdata;
	} mem_req_s;

endpackage : core_ctx_pkg

`default_nettype wire

// File: core_ctx_chk.sv
/* Checker of the core context unit's ports.
 * Assumes it is bound to core_flags_alu_stack_unit. */
`timescale 1ns/10ps
`default_nettype none
module core_ctx_chk (
	// Clock and reset.
	input wire logic                     clk_sys_in,
	input wire logic                     reset_n_in,
	// Watched ports.
	input wire core_ctx_pkg::stack_req_s stack_req_in,
	input wire core_ctx_pkg::cfg_req_s   cfg_req_in,
	input wire logic [7:0]               reg_rd_addr_in,
	input wire logic [7:0]               cfg_rdata_out,
	input wire logic [7:0]               reg_rdata_out,
	input wire logic                     pc_restore_valid_out,
	input wire logic                     busy_out,
	input wire core_ctx_pkg::flags_s     flags_out,
	input wire core_ctx_pkg::mem_req_s   mem_req_out
);
	import core_ctx_pkg::*;
	logic       take;
	stack_cmd_e cmd;
	// A stack request counts only when the sequencer is idle.
	assign take = stack_req_in.valid && !busy_out;
	assign cmd  = stack_req_in.cmd;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	call_store_a: assert property (
		take && (cmd == cmd_call || cmd == cmd_irq) |=> mem_req_out.mem_we
		&& mem_req_out.mem_wdata == $past(stack_req_in.pc[7:0])
		##1 mem_req_out.mem_we
		&& mem_req_out.mem_wdata == $past(stack_req_in.pc[15:8], 2)
		&& mem_req_out.mem_addr == $past(mem_req_out.mem_addr) - 16'h0001)
		else $error("call did not store the counter");
	ret_restore_a: assert property (
		take && (cmd == subroutine_return || cmd == interrupt_return)
		|-> ##3 pc_restore_valid_out ##1 !pc_restore_valid_out)
		else $error("return did not restore the counter");
	push_page_a: assert property (
		take && cmd == cmd_push
		|=> mem_req_out.mem_we && mem_req_out.mem_addr[15:8] == 8'h20)
		else $error("push did not write the stack page");
	pop_nowrite_a: assert property (
		take && cmd == cmd_pop |=> !mem_req_out.mem_we)
		else $error("pop wrote memory");
	usp_page_a: assert property (
		reg_rd_addr_in == 8'h0B |=> reg_rdata_out == 8'h20)
		else $error("user pointer page not 20h");
	ssp_page_a: assert property (
		cfg_req_in.addr == 8'h2C |=> cfg_rdata_out == 8'h20)
		else $error("system pointer page not 20h");
	flag_read_a: assert property (
		reg_rd_addr_in == 8'h26
		|=> reg_rdata_out == {5'h00, $past(flags_out)})
		else $error("flag register differs from flags");
	restore_pulse_a: assert property (
		pc_restore_valid_out |=> !pc_restore_valid_out)
		else $error("restore strobe longer than one cycle");
endmodule : core_ctx_chk
bind core_flags_alu_stack_unit core_ctx_chk i_core_ctx_chk (
	.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
	.stack_req_in(stack_req_in), .cfg_req_in(cfg_req_in),
	.reg_rd_addr_in(reg_rd_addr_in), .cfg_rdata_out(cfg_rdata_out),
	.reg_rdata_out(reg_rdata_out), .busy_out(busy_out),
	.pc_restore_valid_out(pc_restore_valid_out),
	.flags_out(flags_out), .mem_req_out(mem_req_out));
`default_nettype wire

// File: ram_bank_model.sv
/* Behavioural RAM bank on the far side of the core context unit.
 * Assumes clocked writes, unclocked reads and a single stack page. */
`timescale 1ns/10ps
`default_nettype none
module ram_bank_model (
	// Clock.
	input  wire logic                   clk_sys_in,
	// Request from the core and the read answer.
	input  wire core_ctx_pkg::mem_req_s mem_req_in,
	output logic [7:0]                  ram_rdata_out
);
	import core_ctx_pkg::*;
	logic [7:0] mem [256];
	// Each cell starts equal to its location, so a pop is predictable.
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i);
		end
	end
	// Only the low byte selects a cell: every page maps here.
	always @(posedge clk_sys_in) begin
		if (mem_req_in.mem_we) begin
			mem[mem_req_in.mem_addr[7:0]] <= mem_req_in.mem_wdata;
		end
	end
	// Reads answer while the address stands, since the core samples then.
	assign ram_rdata_out = mem[mem_req_in.mem_addr[7:0]];
endmodule : ram_bank_model
`default_nettype wire

// File: testbench.sv
/* Self-checking bench of the core context unit with a RAM bank model.
 * Assumes the package, the header and the design are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import core_ctx_pkg::*;
	logic        clk_sys_in;
	logic        reset_n_in;
	alu_req_s    alu_req_in;
	stack_req_s  stack_req_in;
	cfg_req_s    cfg_req_in;
	logic [7:0]  ram_rdata_in;
	logic [7:0]  reg_rd_addr_in;
	logic [7:0]  cfg_rdata_out;
	logic [7:0]  reg_rdata_out;
	logic        branch_taken_out;
	logic [15:0] pc_restore_out;
	logic        pc_restore_valid_out;
	logic        busy_out;
	flags_s      flags_out;
	mem_req_s    mem_req_out;
	mem_req_s    m1;
	mem_req_s    m2;
	int          mismatches;
	int          comparisons;
	int          cycles;
	alu_op_e     t_op [14] = '{alu_and, alu_or, alu_xor, alu_add, alu_sub,
		alu_shl, alu_shr, alu_bset, alu_bres, register_move_op,
		offset_add_op, offset_subtract_op, alu_rol, alu_ror};
	logic [7:0]  t_exp [14] = '{8'h40, 8'hD8, 8'h98, 8'h18, 8'h78, 8'h90,
		8'h64, 8'h01, 8'h00, 8'hC8, 8'h98, 8'hF8, 8'h91, 8'h64};
	logic [2:0]  t_bit [14] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
	core_flags_alu_stack_unit i_core_flags_alu_stack_unit (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.alu_req_in(alu_req_in), .stack_req_in(stack_req_in),
		.ram_rdata_in(ram_rdata_in), .cfg_req_in(cfg_req_in),
		.reg_rd_addr_in(reg_rd_addr_in), .cfg_rdata_out(cfg_rdata_out),
		.reg_rdata_out(reg_rdata_out), .branch_taken_out(branch_taken_out),
		.pc_restore_out(pc_restore_out), .busy_out(busy_out),
		.pc_restore_valid_out(pc_restore_valid_out),
		.flags_out(flags_out), .mem_req_out(mem_req_out));
	ram_bank_model i_ram_bank_model (.clk_sys_in(clk_sys_in),
		.mem_req_in(mem_req_out), .ram_rdata_out(ram_rdata_in));
	// Free-running clock of 10 ns.
	initial begin
		clk_sys_in = 1'b0;
		forever begin
			#5 clk_sys_in = ~clk_sys_in;
		end
	end
	// Cuts a hang short; the whole run needs well under a thousand cycles.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		cfg_req_in = '{1'b1, 1'b0, a, d};
		@(negedge clk_sys_in);
		cfg_req_in.wr = 1'b0;
	endtask : cfg_wr
	// Both read ports see the address; answers land one edge later.
	task automatic rd(input logic [7:0] a);
		@(negedge clk_sys_in);
		cfg_req_in = '{1'b0, 1'b1, a, 8'h00};
		reg_rd_addr_in = a;
		@(negedge clk_sys_in);
	endtask : rd
	// Waits the busy time that the sequencer is known to hold.
	task automatic go(input stack_cmd_e c, input logic [15:0] p,
		input logic [7:0] r);
		@(negedge clk_sys_in);
		stack_req_in = '{1'b1, c, p, r};
		@(negedge clk_sys_in);
		stack_req_in.valid = 1'b0;
		m1 = mem_req_out;
		@(negedge clk_sys_in);
		m2 = mem_req_out;
		repeat (3) @(negedge clk_sys_in);
	endtask : go
	task automatic alu(input alu_op_e o, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] d, input logic [2:0] s);
		@(negedge clk_sys_in);
		alu_req_in = '{1'b1, o, a, b, d, s};
		@(negedge clk_sys_in);
		alu_req_in.valid = 1'b0;
	endtask : alu
	// A register is loaded by popping the cell just below the pointer.
	task automatic load(input logic [7:0] r, input logic [7:0] v);
		cfg_wr(8'h06, v + 8'h01);
		cfg_wr(8'h05, 8'h20);
		go(cmd_pop, 16'h0000, r);
	endtask : load
	// A register is seen by pushing it and catching the write.
	task automatic res(input logic [7:0] r, input logic [7:0] v);
		go(cmd_push, 16'h0000, r);
		chk("pushed byte", m1.mem_wdata, v);
	endtask : res
	task automatic t_reset();
		rd(8'h0B);
		chk("user page", reg_rdata_out, 8'h20);
		rd(8'h0C);
		chk("user location", reg_rdata_out, 8'h00);
		rd(8'h26);
		chk("flag register", reg_rdata_out, 8'h00);
		rd(8'h2D);
		chk("system location", cfg_rdata_out, 8'hFF);
		rd(8'h2C);
		chk("system page", cfg_rdata_out, 8'h20);
	endtask : t_reset
	task automatic t_user_stack();
		cfg_wr(8'h06, 8'h40);
		cfg_wr(8'h05, 8'h21);
		rd(8'h0C);
		chk("user pointer", reg_rdata_out, 8'h40);
		go(cmd_pop, 16'h0000, 8'h07);
		rd(8'h0C);
		chk("after pop", reg_rdata_out, 8'h3F);
		res(8'h07, 8'h3F);
		chk("push cell", m1.mem_addr, 16'h203F);
		rd(8'h0C);
		chk("after push", reg_rdata_out, 8'h40);
	endtask : t_user_stack
	task automatic t_alu();
		load(8'h01, 8'hC8);
		load(8'h02, 8'h50);
		for (int i = 0; i < 14; i++) begin
			alu(t_op[i], 8'h01, 8'h02, 8'h10 + 8'(i), t_bit[i]);
			res(8'h10 + 8'(i), t_exp[i]);
		end
		alu(alu_bres, 8'h00, 8'h00, 8'h11, 3'h4);
		res(8'h11, 8'hC8);
		alu(alu_btest, 8'h01, 8'h00, 8'h00, 3'h3);
		chk("branch", branch_taken_out, 1'b1);
		alu(alu_btest, 8'h01, 8'h00, 8'h00, 3'h4);
		chk("no branch", branch_taken_out, 1'b0);
		alu(multiply_op, 8'h01, 8'h02, 8'h20, 3'h0);
		res(8'h20, 8'h3E);
		res(8'h21, 8'h80);
		alu(alu_add, 8'h01, 8'h02, 8'h60, 3'h0);
		chk("carry", flags_out, 3'b001);
		alu(alu_sub, 8'h02, 8'h01, 8'h61, 3'h0);
		chk("sign", flags_out, 3'b010);
		alu(alu_xor, 8'h01, 8'h01, 8'h62, 3'h0);
		chk("zero", flags_out, 3'b100);
		load(8'h30, 8'h00);
		load(8'h31, 8'h64);
		load(8'h32, 8'h07);
		alu(divide_op, 8'h30, 8'h32, 8'h00, 3'h0);
		res(8'h30, 8'h0E);
		res(8'h31, 8'h02);
	endtask : t_alu
	task automatic t_context();
		alu(alu_add, 8'h01, 8'h02, 8'h60, 3'h0);
		cfg_wr(8'h2D, 8'h80);
		go(cmd_call, 16'h1234, 8'h00);
		chk("low byte", m1.mem_wdata, 8'h34);
		chk("high byte", m2.mem_wdata, 8'h12);
		chk("call cell", m1.mem_addr, 16'h2080);
		rd(8'h2D);
		chk("pointer after call", cfg_rdata_out, 8'h7E);
		go(subroutine_return, 16'h0000, 8'h00);
		chk("return counter", pc_restore_out, 16'h1234);
		rd(8'h2D);
		chk("pointer after return", cfg_rdata_out, 8'h80);
		chk("normal flags", flags_out, 3'b001);
		go(cmd_irq, 16'hABCD, 8'h00);
		chk("level flags", flags_out, 3'b000);
		alu(alu_xor, 8'h01, 8'h01, 8'h62, 3'h0);
		go(interrupt_return, 16'h0000, 8'h00);
		chk("restored flags", flags_out, 3'b001);
		chk("irq counter", pc_restore_out, 16'hABCD);
		go(cmd_irq, 16'hABCD, 8'h00);
		chk("kept flags", flags_out, 3'b100);
		go(interrupt_return, 16'h0000, 8'h00);
	endtask : t_context
	// Reset for five cycles, then the scenarios in turn.
	initial begin
		reset_n_in = 1'b0;
		alu_req_in = '0;
		stack_req_in = '0;
		cfg_req_in = '0;
		reg_rd_addr_in = 8'h00;
		repeat (5) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		t_reset();
		t_user_stack();
		t_alu();
		t_context();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
